// File: dv/dllb_ctrl_model.sv
`timescale 1ns/1ps
`include "dllb_map.svh"

module dllb_ctrl_model
    import dllb_pkg::*;
(
    output dllb_pins_t pins // Clock, enable, termination and command pins
);
    realtime halfPer = 80.0;
    logic run = 1'b1;

    initial begin
        pins = '0;
        pins.cke = 1'b1;
        #3.3;
        forever begin
            #(halfPer);
            if (run) begin
                pins.clk = ~pins.clk;
            end
        end
    end

    task automatic issue(input logic [2:0] cmd, input logic [1:0] bank, input logic [12:0] addr);
        @(negedge pins.clk);
        pins.cmd <= cmd;
        pins.bank <= bank;
        pins.addr <= addr;
        @(negedge pins.clk);
        pins.cmd <= `DLLB_CMD_NOP;
        // Released lines flip so a stale value is never taken
        pins.bank <= ~bank;
        pins.addr <= ~addr;
    endtask

    task automatic set_cke(input logic v);
        @(negedge pins.clk);
        pins.cke <= v;
    endtask

    // Called only in self refresh or power-down once the hold time has run out
    task automatic change_rate(input realtime hp);
        @(negedge pins.clk);
        run = 1'b0;
        #1000;
        halfPer = hp;
        run = 1'b1;
    endtask
endmodule

// File: dv/tb_dllb_seq.sv
`timescale 1ns/1ps
`include "dllb_map.svh"

module tb_dllb_seq
    import dllb_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic [31:0] d;
    logic dllBypass, readyForCmd, readStrobeStart, inSelfRefresh, clockIgnored, latencyError;
    dllb_pins_t pins;
    int numErrors = 0;
    int checks = 0;
    int cycles = 0;
    int edgeCnt = 0;
    int alLat[4] = '{6, 11, 10, 6};

    dllb_ctrl_model i_ctrl (.pins(pins));

    dllb_seq i_dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .memClk(pins.clk), .memCke(pins.cke), .termCtrl(pins.term),
        .memCmd(pins.cmd), .memBank(pins.bank), .memAddr(pins.addr), .dllBypass(dllBypass),
        .readyForCmd(readyForCmd), .readStrobeStart(readStrobeStart), .inSelfRefresh(inSelfRefresh),
        .clockIgnored(clockIgnored), .latencyError(latencyError));

    always #2 clk = ~clk;

    always @(posedge pins.clk) begin
        edgeCnt++;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            numErrors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, numErrors);
        if (numErrors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            numErrors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    // Mode write; expEdges counts the taking edge plus the busy time
    task automatic mrs(input logic [1:0] sel, input logic [12:0] val, input int expEdges);
        int e0;
        int n;
        e0 = edgeCnt;
        n = 0;
        i_ctrl.issue(`DLLB_CMD_MRS, sel, val);
        while (readyForCmd !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        check(32'(edgeCnt - e0), 32'(expEdges));
    endtask

    // Zero expected means the read is refused
    task automatic rd_cmd(input int exp);
        int e0;
        int n;
        e0 = edgeCnt;
        n = 0;
        i_ctrl.issue(`DLLB_CMD_READ, 2'h0, 13'h0000);
        while (readStrobeStart !== 1'b1 && n < 800) begin
            @(negedge clk);
            n++;
        end
        check(n < 800 ? 32'(edgeCnt - e0) : 32'h0, 32'(exp));
    endtask

    task automatic sr_change(input realtime hp, input logic byp);
        int e0;
        int n;
        n = 0;
        i_ctrl.set_cke(1'b0);
        e0 = edgeCnt;
        i_ctrl.issue(`DLLB_CMD_SRE, 2'h0, 13'h0000);
        while (clockIgnored !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        // One idle edge, the taking edge, then the two hold edges
        check(32'(edgeCnt - e0), 32'h4);
        i_ctrl.change_rate(hp);
        reg_rd(`DLLB_REG_STATUS);
        check(d, {28'h0, 2'b11, 1'b0, byp});
        reg_rd(`DLLB_REG_MR1);
        check(d, {31'h0, byp});
        repeat (4) @(posedge pins.clk);
        i_ctrl.set_cke(1'b1);
        repeat (2) @(posedge pins.clk);
        reg_rd(`DLLB_REG_STATUS);
        check(d, {30'h0, 1'b1, byp});
        $display("self refresh rate change done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        reg_rd(`DLLB_REG_CTRL);
        check(d, {8'h00, `DLLB_HOLD_RST, `DLLB_MOD_RST, `DLLB_MRD_RST});
        reg_rd(`DLLB_REG_STATUS);
        check(d, 32'h0000_0002);
        reg_rd(4'hF);
        check(d, 32'h0000_0000);
        reg_wr(`DLLB_REG_MR1, 32'h0000_0001);
        reg_rd(`DLLB_REG_MR1);
        check(d, 32'h0000_0000);
        reg_wr(`DLLB_REG_CTRL, 32'h0002_0302);
        reg_rd(`DLLB_REG_CTRL);
        check(d, 32'h0002_0302);
        $display("register test done");

        // Refused: self refresh needs the clock enable low
        i_ctrl.issue(`DLLB_CMD_SRE, 2'h0, 13'h0000);
        repeat (3) @(posedge pins.clk);
        // Step off the link edge so the edge count read next is not a race
        #1;
        check({31'h0, inSelfRefresh}, 32'h0);
        mrs(`DLLB_SEL_MR1, 13'h0001, 4);
        check({31'h0, dllBypass}, 32'h1);
        check({31'h0, latencyError}, 32'h1);
        rd_cmd(0);
        mrs(`DLLB_SEL_MR0, 13'h0020, 4);
        check({31'h0, latencyError}, 32'h1);
        mrs(`DLLB_SEL_MR2, 13'h0008, 4);
        check({31'h0, latencyError}, 32'h0);
        $display("bypass entry test done");

        sr_change(60.0, 1'b1);
        for (int al = 0; al < 4; al++) begin
            mrs(`DLLB_SEL_MR1, 13'(1 + 8 * al), 4);
            rd_cmd(alLat[al]);
        end
        mrs(`DLLB_SEL_MR1, 13'h0001, 4);
        $display("bypass read test done");

        sr_change(80.0, 1'b1);
        reg_wr(`DLLB_REG_CTRL, 32'h0002_0204);
        mrs(`DLLB_SEL_MR1, 13'h0000, 5);
        check({31'h0, dllBypass}, 32'h0);
        mrs(`DLLB_SEL_MR0, 13'h0120, 5);
        reg_rd(`DLLB_REG_MR0);
        check(d, 32'h0000_0120);
        $display("normal mode return test done");

        i_ctrl.set_cke(1'b0);
        repeat (2) @(posedge pins.clk);
        i_ctrl.change_rate(80.0);
        repeat (4) @(posedge pins.clk);
        i_ctrl.set_cke(1'b1);
        repeat (2) @(posedge pins.clk);
        reg_rd(`DLLB_REG_STATUS);
        check(d, 32'h0000_0002);
        mrs(`DLLB_SEL_MR0, 13'h0120, 5);
        repeat (16) @(posedge pins.clk);
        i_ctrl.issue(`DLLB_CMD_LONG_IMPEDANCE_CALIBRATION, 2'h0, 13'h0000);
        // The command returns on a falling link edge, so one idle edge precedes the read
        rd_cmd(8);
        $display("power-down rate change test done");
        stop_test();
    end
endmodule

// File: rtl/dllb_cnt.sv
`timescale 1ns/1ps
`include "dllb_map.svh"

module dllb_cnt
    import dllb_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic load, // Load start value
    input wire logic [WIDTH-1:0] loadVal, // Start value
    input wire logic tick, // Count one link clock edge
    output logic zero // Count has reached zero
);

    if (WIDTH != 8) begin : g_width_check
        $error("dllb_cnt supports WIDTH 8 only");
    end

    dllb_cnt_t st_r;
    dllb_cnt_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (load) begin
            st_nxt.count = loadVal;
        end else if (tick && st_r.count != 8'h00) begin
            st_nxt.count = st_r.count - 8'h01;
        end
        st_nxt.zero = (st_nxt.count == 8'h00);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '{count: 8'h00, zero: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign zero = st_r.zero;

endmodule

// File: rtl/dllb_map.svh
`ifndef DLLB_MAP_SVH
`define DLLB_MAP_SVH

// Register port word addresses
`define DLLB_REG_CTRL 4'h0
`define DLLB_REG_STATUS 4'h1
`define DLLB_REG_MR0 4'h2
`define DLLB_REG_MR1 4'h3
`define DLLB_REG_MR2 4'h4

// Control register fields and reset values (link clock cycles)
`define DLLB_CTRL_MRD_LSB 0
`define DLLB_CTRL_MOD_LSB 8
`define DLLB_CTRL_HOLD_LSB 16
`define DLLB_MRD_RST 8'h04
`define DLLB_MOD_RST 8'h0C
`define DLLB_HOLD_RST 8'h05

// Status register bit positions
`define DLLB_ST_BYPASS 0
`define DLLB_ST_READY 1
`define DLLB_ST_SELFREF 2
`define DLLB_ST_CLKIGN 3
`define DLLB_ST_LATERR 4

// Mode register fields
`define DLLB_MR1_BYPASS_BIT 0
`define DLLB_MR0_LOOP_RESET_BIT 8
`define DLLB_MR0_RL_LSB 4
`define DLLB_MR1_AL_LSB 3
`define DLLB_MR2_WL_LSB 3
`define DLLB_RL_BASE 8'h04
`define DLLB_WL_BASE 8'h05
`define DLLB_BYPASS_LAT 8'h06

// Mode register select on the bank pins
`define DLLB_SEL_MR0 2'h0
`define DLLB_SEL_MR1 2'h1
`define DLLB_SEL_MR2 2'h2

// Command codes on the command pins
`define DLLB_CMD_NOP 3'h0
`define DLLB_CMD_MRS 3'h1
`define DLLB_CMD_SRE 3'h2
`define DLLB_CMD_READ 3'h3
`define DLLB_CMD_LONG_IMPEDANCE_CALIBRATION 3'h4

`endif

// File: rtl/dllb_pkg.sv
package dllb_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SR_HOLD = 3'b010,
        ST_SR_FREE = 3'b100
    } dllb_state_t;

    typedef struct packed {
        logic clk;
        logic cke;
        logic term;
        logic [2:0] cmd;
        logic [1:0] bank;
        logic [12:0] addr;
    } dllb_pins_t;

    typedef struct packed {
        logic [7:0] count;
        logic zero;
    } dllb_cnt_t;

endpackage

// File: rtl/dllb_seq.sv
`timescale 1ns/1ps
`include "dllb_map.svh"

module dllb_seq
    import dllb_pkg::*;
(
    input wire logic clk, // System clock, 250 MHz
    input wire logic reset_n, // Async reset, active low
    input wire logic [3:0] regAddr, // Register word address
    input wire logic [31:0] regWdata, // Register write data
    input wire logic regWr, // Register write strobe
    input wire logic regRd, // Register read strobe
    output logic [31:0] regRdata, // Read data, cycle after strobe
    input wire logic memClk, // Memory clock pin
    input wire logic memCke, // Clock enable pin
    input wire logic termCtrl, // Termination control pin
    input wire logic [2:0] memCmd, // Command pins
    input wire logic [1:0] memBank, // Mode register select pins
    input wire logic [12:0] memAddr, // Mode register data pins
    output logic dllBypass, // Delay loop bypassed
    output logic readyForCmd, // Idle with the busy wait over; a pending read still blocks commands
    output logic readStrobeStart, // Read strobe window opens
    output logic inSelfRefresh, // Self refresh active
    output logic clockIgnored, // Clock state is ignored
    output logic latencyError // Latency illegal in bypass
);

    typedef struct packed {
        dllb_pins_t sync1;
        dllb_pins_t sync2;
        logic clkPrev;
        dllb_state_t state;
        logic [12:0] mr0;
        logic [12:0] mr1;
        logic [12:0] mr2;
        logic [7:0] mrdCyc;
        logic [7:0] modCyc;
        logic [7:0] holdCyc;
        logic readPending;
        logic [31:0] rdata;
        logic bypass;
        logic ready;
        logic strobe;
        logic selfRef;
        logic clkIgn;
        logic latErr;
    } dllb_seq_st_t;

    dllb_seq_st_t st_r;
    dllb_seq_st_t st_nxt;

    function automatic logic [7:0] readLat(input logic [12:0] mr0);
        readLat = `DLLB_RL_BASE + {5'h00, mr0[`DLLB_MR0_RL_LSB +: 3]};
    endfunction

    function automatic logic [7:0] writeLat(input logic [12:0] mr2);
        writeLat = `DLLB_WL_BASE + {5'h00, mr2[`DLLB_MR2_WL_LSB +: 3]};
    endfunction

    function automatic logic [7:0] addLat(input logic [12:0] mr0, input logic [12:0] mr1);
        logic [7:0] rl;
        rl = readLat(mr0);
        case (mr1[`DLLB_MR1_AL_LSB +: 2])
            2'h1: addLat = rl - 8'h01;
            2'h2: addLat = rl - 8'h02;
            default: addLat = 8'h00;
        endcase
    endfunction

    logic clkEdge;
    logic cmdTake;
    logic mrsTake;
    logic readTake;
    logic sreTake;
    logic busyLoad;
    logic [7:0] busyVal;
    logic busyZero;
    logic readZero;
    logic [7:0] readDelay;
    logic latBad;

    assign clkEdge = st_r.sync2.clk && !st_r.clkPrev;
    assign latBad = st_r.bypass && (readLat(st_r.mr0) != `DLLB_BYPASS_LAT ||
        writeLat(st_r.mr2) != `DLLB_BYPASS_LAT);
    // Commands are taken on a clock edge only while idle and past every wait
    assign cmdTake = clkEdge && st_r.state == ST_IDLE && busyZero && !st_r.readPending;
    assign mrsTake = cmdTake && st_r.sync2.cmd == `DLLB_CMD_MRS;
    assign sreTake = cmdTake && st_r.sync2.cmd == `DLLB_CMD_SRE && !st_r.sync2.cke;
    assign readTake = cmdTake && st_r.sync2.cmd == `DLLB_CMD_READ && !latBad;
    assign readDelay = addLat(st_r.mr0, st_r.mr1) + readLat(st_r.mr0) -
        (st_r.bypass ? 8'h01 : 8'h00);
    assign busyLoad = mrsTake || sreTake;
    assign busyVal = sreTake ? st_r.holdCyc :
        (st_r.mrdCyc > st_r.modCyc ? st_r.mrdCyc : st_r.modCyc);

    dllb_cnt #(.WIDTH(8)) u_busy (
        .clk(clk),
        .reset_n(reset_n),
        .load(busyLoad),
        .loadVal(busyVal),
        .tick(clkEdge),
        .zero(busyZero)
    );

    dllb_cnt #(.WIDTH(8)) u_read (
        .clk(clk),
        .reset_n(reset_n),
        .load(readTake),
        .loadVal(readDelay),
        .tick(clkEdge),
        .zero(readZero)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = '{clk: memClk, cke: memCke, term: termCtrl, cmd: memCmd, bank: memBank, addr: memAddr};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.clkPrev = st_r.sync2.clk;
        st_nxt.strobe = 1'b0;
        st_nxt.rdata = 32'h0000_0000;
        if (regWr && regAddr == `DLLB_REG_CTRL) begin
            st_nxt.mrdCyc = regWdata[`DLLB_CTRL_MRD_LSB +: 8];
            st_nxt.modCyc = regWdata[`DLLB_CTRL_MOD_LSB +: 8];
            st_nxt.holdCyc = regWdata[`DLLB_CTRL_HOLD_LSB +: 8];
        end
        if (regRd) begin
            case (regAddr)
                `DLLB_REG_CTRL: st_nxt.rdata = {8'h00, st_r.holdCyc, st_r.modCyc, st_r.mrdCyc};
                `DLLB_REG_STATUS: st_nxt.rdata = {27'h0000000, st_r.latErr, st_r.clkIgn,
                    st_r.selfRef, st_r.ready, st_r.bypass};
                `DLLB_REG_MR0: st_nxt.rdata = {19'h00000, st_r.mr0};
                `DLLB_REG_MR1: st_nxt.rdata = {19'h00000, st_r.mr1};
                `DLLB_REG_MR2: st_nxt.rdata = {19'h00000, st_r.mr2};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        if (mrsTake) begin
            case (st_r.sync2.bank)
                `DLLB_SEL_MR0: st_nxt.mr0 = st_r.sync2.addr;
                `DLLB_SEL_MR1: st_nxt.mr1 = st_r.sync2.addr;
                `DLLB_SEL_MR2: st_nxt.mr2 = st_r.sync2.addr;
                default: st_nxt.mr0 = st_r.mr0;
            endcase
        end
        if (readTake) begin
            st_nxt.readPending = 1'b1;
        end else if (st_r.readPending && readZero) begin
            st_nxt.readPending = 1'b0;
            st_nxt.strobe = 1'b1;
        end
        // Mode registers are left alone in self refresh; contents stay intact
        case (st_r.state)
            ST_IDLE: begin
                if (sreTake) begin
                    st_nxt.state = ST_SR_HOLD;
                end
            end
            ST_SR_HOLD: begin
                if (st_r.sync2.cke) begin
                    st_nxt.state = ST_IDLE;
                end else if (busyZero) begin
                    st_nxt.state = ST_SR_FREE;
                end
            end
            ST_SR_FREE: begin
                if (st_r.sync2.cke) begin
                    st_nxt.state = ST_IDLE;
                end
            end
            default: st_nxt.state = ST_IDLE;
        endcase
        st_nxt.bypass = st_nxt.mr1[`DLLB_MR1_BYPASS_BIT];
        st_nxt.latErr = latBad;
        st_nxt.ready = st_r.state == ST_IDLE && busyZero && !busyLoad;
        st_nxt.selfRef = st_nxt.state != ST_IDLE;
        st_nxt.clkIgn = st_nxt.state == ST_SR_FREE;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
            st_r.state <= ST_IDLE;
            st_r.mrdCyc <= `DLLB_MRD_RST;
            st_r.modCyc <= `DLLB_MOD_RST;
            st_r.holdCyc <= `DLLB_HOLD_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdata = st_r.rdata;
    assign dllBypass = st_r.bypass;
    assign readyForCmd = st_r.ready;
    assign readStrobeStart = st_r.strobe;
    assign inSelfRefresh = st_r.selfRef;
    assign clockIgnored = st_r.clkIgn;
    assign latencyError = st_r.latErr;

    // Helper counters for the checks below
    logic [7:0] readEdges;
    logic [7:0] readExp;
    logic [7:0] mrsEdges;
    logic [7:0] mrsExp;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readEdges <= 8'h00;
            readExp <= 8'h00;
            mrsEdges <= 8'h00;
            mrsExp <= 8'h00;
        end else begin
            if (readTake) begin
                readEdges <= 8'h00;
                readExp <= readDelay;
            end else if (clkEdge && readEdges != 8'hFF) begin
                readEdges <= readEdges + 8'h01;
            end
            if (mrsTake) begin
                mrsEdges <= 8'h00;
                mrsExp <= busyVal;
            end else if (clkEdge && mrsEdges != 8'hFF) begin
                mrsEdges <= mrsEdges + 8'h01;
            end
        end
    end

    property p_bypass_bit;
        @(posedge clk) disable iff (!reset_n)
        mrsTake && st_r.sync2.bank == `DLLB_SEL_MR1 |=> dllBypass == $past(st_r.sync2.addr[0]);
    endproperty
    a_bypass_bit: assert property (p_bypass_bit) else $error("bypass does not follow mode bit");

    property p_lat_flag;
        @(posedge clk) disable iff (!reset_n)
        latBad |=> latencyError;
    endproperty
    a_lat_flag: assert property (p_lat_flag) else $error("latency error not flagged");

    property p_no_read_bad_lat;
        @(posedge clk) disable iff (!reset_n)
        latBad |-> !readTake;
    endproperty
    a_no_read_bad_lat: assert property (p_no_read_bad_lat) else $error("read taken with bad latency");

    property p_strobe_delay;
        @(posedge clk) disable iff (!reset_n)
        readStrobeStart |-> readEdges == readExp;
    endproperty
    a_strobe_delay: assert property (p_strobe_delay) else $error("strobe window at wrong edge");

    property p_busy_after_mrs;
        @(posedge clk) disable iff (!reset_n)
        mrsTake |=> !readyForCmd ##1 !readyForCmd;
    endproperty
    a_busy_after_mrs: assert property (p_busy_after_mrs) else $error("ready too soon after mode write");

    property p_ready_wait;
        @(posedge clk) disable iff (!reset_n)
        $rose(readyForCmd) && !inSelfRefresh |-> mrsEdges >= mrsExp;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready before mode delay elapsed");

    property p_clk_ignored;
        @(posedge clk) disable iff (!reset_n)
        clockIgnored |-> inSelfRefresh && !readStrobeStart && !cmdTake;
    endproperty
    a_clk_ignored: assert property (p_clk_ignored) else $error("clock ignored outside self refresh");

    property p_keep_contents;
        @(posedge clk) disable iff (!reset_n)
        inSelfRefresh && $past(inSelfRefresh) |-> $stable({st_r.mr0, st_r.mr1, st_r.mr2});
    endproperty
    a_keep_contents: assert property (p_keep_contents) else $error("mode registers changed in self refresh");

    c_bypass: cover property (@(posedge clk) disable iff (!reset_n) $rose(dllBypass));
    c_strobe: cover property (@(posedge clk) disable iff (!reset_n) readStrobeStart && dllBypass);
    c_sr_free: cover property (@(posedge clk) disable iff (!reset_n) $rose(clockIgnored));
    c_sr_exit: cover property (@(posedge clk) disable iff (!reset_n) $fell(inSelfRefresh));

endmodule
